// ==== inc/pan_consts.svh ====
// constants for the auto-negotiation control block
// assumes a 100 MHz device clock and a 5-bit register index
`ifndef PAN_CONSTS_SVH
`define PAN_CONSTS_SVH
// register indices
`define PAN_REG_BC 5'h00
`define PAN_REG_BS 5'h01
`define PAN_REG_ADV 5'h04
`define PAN_REG_LP 5'h05
`define PAN_REG_EXP 5'h06
`define PAN_REG_PSS 5'h10
// basic control bit positions
`define PAN_BC_DUPLEX 8
`define PAN_BC_RESTART 9
`define PAN_BC_ANEN 12
`define PAN_BC_SPEED 13
// fixed values
`define PAN_BS_FIXED 16'h7849
`define PAN_LP_PD100 16'h0081
`define PAN_LP_PD10 16'h0021
`define PAN_SELECTOR 5'h01
`define PAN_ADV_ALL 4'hF
// timing
`define PAN_CLK_KHZ 100000
`define PAN_BREAK_MS 1500
`endif

// ==== inc/pan_pkg.sv ====
// types for the auto-negotiation control block
// assumes pan_consts.svh holds the numbers
package pan_pkg;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_BREAK = 2'b01,
    ST_ABIL = 2'b10,
    ST_LINK = 2'b11
  } pan_state_e;
endpackage : pan_pkg

// ==== design/pan_ctrl.sv ====
// auto-negotiation control for a 10/100 twisted-pair transceiver
// assumes same-clock register port and same-clock page receiver;
// straps and receiver link levels arrive asynchronously
//
// Overview of operation
// - enable strap low: mode straps force 10/100 speed and half/full duplex.
// - enable strap high: mode straps choose which abilities are advertised.
// - straps are sampled after reset and set advertisement bits 8 to 5.
// - software writes to basic control change negotiation behaviour later.
// - while negotiating, advertisement register contents go out in pulse bursts.
// - mode straps never change basic control register contents.
// - status summary speed and duplex valid only if disabled or complete.
// - resolve to highest common ability: 100 full, 100 half, 10 full, 10 half.
// - control speed and duplex bits act only while negotiation is disabled.
// - basic status capability bits fixed; the T4 and both T2 abilities read clear.
// - basic status reports completion, remote fault, link, preamble suppression.
// - all abilities advertised by default; written clears remove them.
// - partner register captures base and next-page words received.
// - parallel detection loads partner register with 0081h or 0021h.
// - expansion reports fault, next-page abilities, page received, partner able.
// - both receivers report link; lone valid link selects matching technology.
// - after parallel detection partner-able reads zero while complete is set.
// - in parallel detect, two good links at once sets fault; no link does not.
// - writing restart bit with the enable bit set restarts negotiation while it is enabled.
// - losing link in a negotiated mode resumes negotiation.
// - renegotiation silences transmit for the break timer, then bursts resume.
// - pause strap latched into advertisement pause bit; low gives one.
`timescale 1ns/10ps
`include "pan_consts.svh"
module pan_ctrl #(
  parameter int unsigned BREAK_CYC = `PAN_BREAK_MS * `PAN_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic neg_strap_enable,
  input wire logic mode_strap_high,
  input wire logic mode_strap_low,
  input wire logic pause_strap_n,
  input wire logic link10_ok,
  input wire logic link100_ok,
  input wire logic rx_page_valid,
  input wire logic [15:0] rx_page,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic flp_tx_en,
  output logic tx_halt,
  output logic [15:0] tx_word,
  output logic speed_100,
  output logic full_duplex,
  output logic link_up,
  output pan_pkg::pan_state_e neg_state
);
  import pan_pkg::*;
  localparam int CW = $clog2(BREAK_CYC + 1);

  // ----------------------------------------
  // synchronisers and strap latch
  // ----------------------------------------
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [1:0] latch_cnt_q;
  logic strap_done_q;
  logic [1:0] f_mode_q;
  wire strap_latch = !strap_done_q && latch_cnt_q == 2'h3;
  wire s_en = sync2_q[5];
  wire [1:0] s_mode = sync2_q[4:3];
  wire s_pause_n = sync2_q[2];
  wire l10 = sync2_q[1];
  wire l100 = sync2_q[0];

  // pins are asynchronous; two flops before use
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {neg_strap_enable, mode_strap_high, mode_strap_low, pause_strap_n, link10_ok, link100_ok};
      sync2_q <= sync1_q;
    end
  end

  // straps caught once the synchroniser has filled after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      f_mode_q <= 2'h0;
    end else if (!strap_done_q) begin
      latch_cnt_q <= latch_cnt_q + 2'h1;
      strap_done_q <= strap_latch;
      if (strap_latch) f_mode_q <= s_mode;
    end
  end

  // strap code to advertised abilities, bits 8..5
  function automatic logic [3:0] pan_strap_adv(input logic en, input logic [1:0] m);
    logic [3:0] a;
    a = `PAN_ADV_ALL; // forced straps keep the full default
    if (en) begin
      unique case (m)
        2'b00: a = 4'h3;
        2'b01: a = 4'hC;
        2'b10: a = 4'h5;
        2'b11: a = 4'hF;
      endcase
    end
    return a;
  endfunction : pan_strap_adv

  // highest common ability: {speed, full}
  function automatic logic [1:0] pan_best(input logic [3:0] c);
    logic [1:0] r;
    r = 2'b00;
    if (c[3]) r = 2'b11;
    else if (c[2]) r = 2'b10;
    else if (c[1]) r = 2'b01;
    return r;
  endfunction : pan_best

  // ----------------------------------------
  // register decode and events
  // ----------------------------------------
  logic [15:0] bc_q;
  logic [15:0] adv_q;
  logic [15:0] lp_q;
  logic lp_able_q;
  logic page_rcvd_q;
  logic pdf_q;
  logic sw_own_q;
  logic [1:0] res_q;
  logic [CW-1:0] cnt_q;
  logic up_seen_q;
  logic [CW-1:0] quiet_q;
  pan_state_e st_q;
  pan_state_e st_d;
  wire wr_bc = reg_wr && reg_addr == `PAN_REG_BC;
  wire wr_adv = reg_wr && reg_addr == `PAN_REG_ADV;
  wire rd_exp = reg_rd && reg_addr == `PAN_REG_EXP;
  wire negotiation_strap_enable = bc_q[`PAN_BC_ANEN];
  // only a 0->1 edge of the enable bit starts negotiation; while it is set, a forced start uses the restart bit instead
  wire an_start = (wr_bc && reg_wdata[`PAN_BC_ANEN] && !negotiation_strap_enable) || (strap_latch && s_en);
  wire restart = wr_bc && reg_wdata[`PAN_BC_RESTART] && reg_wdata[`PAN_BC_ANEN] && negotiation_strap_enable;
  wire an_off = wr_bc && !reg_wdata[`PAN_BC_ANEN];
  wire brk_done = cnt_q == CW'(BREAK_CYC - 1);
  wire [3:0] common = adv_q[8:5] & rx_page[8:5];
  wire page_ok = rx_page_valid && |common;
  wire pd_one = l10 ^ l100;
  wire pd_both = l10 && l100;
  wire res_link = res_q[1] ? l100 : l10;
  wire complete = st_q == ST_LINK;

  // ----------------------------------------
  // negotiation state machine
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_OFF: if (an_start) st_d = ST_BREAK;
      ST_BREAK: if (brk_done) st_d = ST_ABIL;
      ST_ABIL: if (page_ok || pd_one) st_d = ST_LINK;
      ST_LINK: if (restart || (up_seen_q && !res_link)) st_d = ST_BREAK;
    endcase
    if (restart) st_d = ST_BREAK;
    if (an_off) st_d = ST_OFF;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) st_q <= ST_OFF;
    else st_q <= st_d;
  end

  // break-link timer runs only while silent
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= '0;
    else if (st_q != ST_BREAK || st_d != ST_BREAK || restart) cnt_q <= '0; // a new request rearms the timer
    else cnt_q <= cnt_q + CW'(1);
  end

  // ----------------------------------------
  // control and advertisement registers
  // ----------------------------------------
  // the enable strap reaches only the enable bit; mode straps never set speed or duplex
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bc_q <= 16'h0000;
      sw_own_q <= 1'b0;
    end else begin
      if (strap_latch) bc_q[`PAN_BC_ANEN] <= s_en;
      if (wr_bc) begin
        bc_q <= {2'b00, reg_wdata[13:10], 1'b0, reg_wdata[8], 8'h00};
        sw_own_q <= 1'b1;
      end
      if (st_d == ST_BREAK && st_q != ST_BREAK) bc_q[`PAN_BC_RESTART] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) adv_q <= {7'h00, 4'hF, `PAN_SELECTOR};
    else if (strap_latch) adv_q <= {5'h00, !s_pause_n, 1'b0, pan_strap_adv(s_en, s_mode), `PAN_SELECTOR};
    else if (wr_adv) adv_q <= {reg_wdata[15:5], `PAN_SELECTOR};
  end

  // ----------------------------------------
  // partner capture and expansion status
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lp_q <= 16'h0000;
      lp_able_q <= 1'b0;
      res_q <= 2'b00;
    end else if (rx_page_valid && (st_q == ST_ABIL || st_q == ST_LINK)) begin
      lp_q <= rx_page;
      lp_able_q <= 1'b1;
      if (st_q == ST_ABIL) res_q <= pan_best(common);
    end else if (st_q == ST_ABIL && pd_one) begin
      lp_q <= l100 ? `PAN_LP_PD100 : `PAN_LP_PD10;
      lp_able_q <= 1'b0;
      res_q <= {l100, 1'b0};
    end
  end

  // set wins over clear-on-read for page received
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_rcvd_q <= 1'b0;
      pdf_q <= 1'b0;
      up_seen_q <= 1'b0;
      quiet_q <= '0;
    end else begin
      page_rcvd_q <= (rx_page_valid && st_q != ST_OFF) || (page_rcvd_q && !rd_exp);
      pdf_q <= (st_q == ST_ABIL && pd_both && !rx_page_valid) || (pdf_q && !rd_exp);
      up_seen_q <= complete && (up_seen_q || res_link); // loss counts only once the link was up
      quiet_q <= tx_halt ? quiet_q + CW'(1) : '0; // silence length for the break check
    end
  end

  // ----------------------------------------
  // operating mode and read mux
  // ----------------------------------------
  wire pss_valid = !negotiation_strap_enable || complete;
  wire spd_d = (st_q == ST_OFF) ? (sw_own_q ? bc_q[`PAN_BC_SPEED] : f_mode_q[1]) : res_q[1];
  wire dpx_d = (st_q == ST_OFF) ? (sw_own_q ? bc_q[`PAN_BC_DUPLEX] : f_mode_q[0]) : res_q[0];
  wire lnk_d = complete || (st_q == ST_OFF && strap_done_q && (spd_d ? l100 : l10));
  wire [15:0] bs_w = `PAN_BS_FIXED | {10'h000, complete, lp_q[13] && lp_able_q, 1'b0, lnk_d, 2'b00};
  wire [15:0] exp_w = {11'h000, pdf_q, lp_q[15] && lp_able_q, 1'b0, page_rcvd_q, lp_able_q};
  wire [15:0] pss_w = {11'h000, complete, 1'b0, pss_valid && dpx_d, pss_valid && !spd_d, lnk_d};
  wire [15:0] rd_w = (reg_addr == `PAN_REG_BC) ? bc_q :
                     (reg_addr == `PAN_REG_BS) ? bs_w :
                     (reg_addr == `PAN_REG_ADV) ? adv_q :
                     (reg_addr == `PAN_REG_LP) ? lp_q :
                     (reg_addr == `PAN_REG_EXP) ? exp_w :
                     (reg_addr == `PAN_REG_PSS) ? pss_w : 16'h0000;

  // outputs registered; burst and halt enables come from the next state, so they switch with the state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
      flp_tx_en <= 1'b0;
      tx_halt <= 1'b0;
      tx_word <= 16'h0000;
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
      link_up <= 1'b0;
      neg_state <= ST_OFF;
    end else begin
      if (reg_rd) reg_rdata <= rd_w;
      flp_tx_en <= st_d == ST_ABIL;
      tx_halt <= st_d == ST_BREAK;
      tx_word <= adv_q;
      speed_100 <= spd_d;
      full_duplex <= dpx_d;
      link_up <= lnk_d;
      neg_state <= st_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_restart;
    restart && !an_off;
  endsequence
  sequence s_quiet;
    tx_halt && !flp_tx_en;
  endsequence
  property p_restart;
    @(posedge clk) disable iff (!rst_b) s_restart |=> st_q == ST_BREAK ##0 s_quiet;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not silence link");
  property p_break_len;
    @(posedge clk) disable iff (!rst_b) $rose(flp_tx_en) |-> quiet_q >= CW'(BREAK_CYC);
  endproperty
  a_break_len: assert property (p_break_len) else $error("break left early");
  property p_burst;
    @(posedge clk) disable iff (!rst_b) neg_state == ST_ABIL |-> flp_tx_en && !tx_halt ##1 tx_word == $past(adv_q);
  endproperty
  a_burst: assert property (p_burst) else $error("bursts not sent");
  property p_pd;
    @(posedge clk) disable iff (!rst_b) (complete && !lp_able_q) |-> (lp_q == `PAN_LP_PD100 || lp_q == `PAN_LP_PD10);
  endproperty
  a_pd: assert property (p_pd) else $error("parallel detect word wrong");
  property p_prio;
    @(posedge clk) disable iff (!rst_b) (st_q == ST_ABIL && page_ok && common[3] && !restart && !an_off) |=> ##1 speed_100 && full_duplex;
  endproperty
  a_prio: assert property (p_prio) else $error("priority not highest");
  property p_lost;
    @(posedge clk) disable iff (!rst_b) (complete && up_seen_q && !res_link && !an_off) |=> st_q == ST_BREAK;
  endproperty
  a_lost: assert property (p_lost) else $error("link loss not renegotiated");
  property p_selfclr;
    @(posedge clk) disable iff (!rst_b) $rose(tx_halt) |-> !bc_q[`PAN_BC_RESTART];
  endproperty
  a_selfclr: assert property (p_selfclr) else $error("restart bit stuck");
  property p_pdf;
    @(posedge clk) disable iff (!rst_b) (st_q == ST_ABIL && pd_both && !rx_page_valid) |=> pdf_q;
  endproperty
  a_pdf: assert property (p_pdf) else $error("fault not flagged");
  property p_pss;
    @(posedge clk) disable iff (!rst_b) !pss_valid |-> pss_w[2:1] == 2'b00;
  endproperty
  a_pss: assert property (p_pss) else $error("summary valid too early");
endmodule : pan_ctrl

// ==== sim/pan_partner.sv ====
// remote link partner model: base pages and receiver link levels
// assumes the bench asks for pages and links on the device clock
`timescale 1ns/10ps
module pan_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic send,
  input wire logic [15:0] word,
  input wire logic want10,
  input wire logic want100,
  output logic rx_page_valid,
  output logic [15:0] rx_page,
  output logic link10_ok,
  output logic link100_ok
);
  // word toggles outside its pulse so a stale page never looks valid
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_page_valid <= 1'b0;
      rx_page <= 16'h0000;
      link10_ok <= 1'b0;
      link100_ok <= 1'b0;
    end else begin
      rx_page_valid <= send;
      rx_page <= send ? word : ~rx_page;
      link10_ok <= want10;
      link100_ok <= want100;
    end
  end
endmodule : pan_partner

// ==== sim/pan_ctrl_tb.sv ====
// self-checking bench for pan_ctrl with a remote partner model
// assumes pan_partner and the design files are compiled first
`timescale 1ns/10ps
module pan_ctrl_tb;
  import pan_pkg::*;
  localparam int unsigned BRK = 20;
  logic clk = 1'b0, rst_b = 1'b0, en_s = 1'b0, m_hi = 1'b0, m_lo = 1'b0, pause_n = 1'b1;
  logic send = 1'b0, l10 = 1'b0, l100 = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_p = 1'b0;
  logic [15:0] word = 16'h0000, reg_wdata = 16'h0000, a, w, e_v, m_v;
  logic [4:0] reg_addr = 5'h00;
  logic rx_page_valid, link10_ok, link100_ok, flp_tx_en, tx_halt, speed_100, full_duplex, link_up;
  logic [15:0] rx_page, reg_rdata, tx_word;
  pan_state_e neg_state;
  logic [15:0] exp_q[$], msk_q[$];
  int error_cnt = 0, n_compared = 0, cyc = 0;
  logic [31:0] r;
  always #5 clk = ~clk;
  pan_partner u_far (.clk(clk), .rst_b(rst_b), .send(send), .word(word), .want10(l10), .want100(l100),
    .rx_page_valid(rx_page_valid), .rx_page(rx_page), .link10_ok(link10_ok), .link100_ok(link100_ok));
  pan_ctrl #(.BREAK_CYC(BRK)) u_dut (.clk(clk), .rst_b(rst_b), .neg_strap_enable(en_s),
    .mode_strap_high(m_hi), .mode_strap_low(m_lo), .pause_strap_n(pause_n), .link10_ok(link10_ok),
    .link100_ok(link100_ok), .rx_page_valid(rx_page_valid), .rx_page(rx_page), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flp_tx_en(flp_tx_en),
    .tx_halt(tx_halt), .tx_word(tx_word), .speed_100(speed_100), .full_duplex(full_duplex),
    .link_up(link_up), .neg_state(neg_state));
  // ----
  // checking helpers
  // ----
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // hang guard, far above the several hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // read data stands from the edge after the request; look mid-cycle
  always @(posedge clk) rd_p <= reg_rd;
  always @(negedge clk) begin
    if (rd_p) begin
      e_v = exp_q.pop_front();
      m_v = msk_q.pop_front();
      chk(reg_rdata & m_v, e_v & m_v);
    end
  end
  task automatic rd(input logic [4:0] ad, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, ad};
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic wr(input logic [4:0] ad, input logic [15:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic wait_st(input pan_state_e s);
    for (int i = 0; i < 200 && neg_state !== s; i++) @(negedge clk);
    chk({14'h0, neg_state}, {14'h0, s});
  endtask : wait_st
  // straps are held through reset; writes only after the strap load
  task automatic boot(input logic en, input logic [1:0] md, input logic pn);
    @(posedge clk);
    {rst_b, en_s, m_hi, m_lo, pause_n, l10, l100} <= {1'b0, en, md, pn, 2'b00};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : boot
  function automatic logic [1:0] res(input logic [3:0] c);
    return c[3] ? 2'b11 : c[2] ? 2'b10 : c[1] ? 2'b01 : 2'b00;
  endfunction : res
  task automatic neg(input logic [15:0] pg, input logic [15:0] ad);
    logic [1:0] rs;
    rs = res(pg[8:5] & ad[8:5]);
    wait_st(ST_ABIL);
    chk({14'h0, flp_tx_en, tx_halt}, 16'h0002);
    chk(tx_word, ad);
    @(posedge clk);
    {send, word} <= {1'b1, pg};
    @(posedge clk);
    send <= 1'b0;
    repeat (6) @(negedge clk);
    rd(5'h05, pg, 16'hFFFF);
    if ((pg[8:5] & ad[8:5]) == 4'h0) begin
      chk({14'h0, neg_state}, {14'h0, ST_ABIL});
    end else begin
      chk({12'h0, neg_state, speed_100, full_duplex}, {12'h0, ST_LINK, rs});
      rd(5'h01, 16'h7869 | {11'h0, pg[13], 4'h0}, 16'hFFFB);
      rd(5'h06, 16'h0003, 16'h001F);
      rd(5'h10, {11'h0, 1'b1, 1'b0, rs[0], ~rs[1], 1'b0}, 16'h0016);
    end
  endtask : neg
  task automatic restart();
    wr(5'h00, 16'h1200);
    wait_st(ST_BREAK);
    repeat (BRK - 4) @(negedge clk);
    chk({14'h0, tx_halt, flp_tx_en}, 16'h0002);
    rd(5'h00, 16'h0000, 16'h0200);
  endtask : restart
  // ----
  // main sequence
  // ----
  initial begin
    r = $urandom(32'h43d3004e);
    for (int md = 0; md < 4; md++) begin
      boot(1'b0, md[1:0], 1'b1);
      chk({12'h0, neg_state, speed_100, full_duplex}, {12'h0, ST_OFF, md[1:0]});
      rd(5'h04, 16'h01E1, 16'hFFFF);
      rd(5'h00, 16'h0000, 16'h2100);
      rd(5'h10, {13'h0, md[0], ~md[1], 1'b0}, 16'h0006);
      boot(1'b1, md[1:0], 1'b0);
      a = {5'h0, 1'b1, 1'b0, md == 0 ? 4'h3 : md == 1 ? 4'hC : md == 2 ? 4'h5 : 4'hF, 5'h01};
      rd(5'h04, a, 16'hFFFF);
      rd(5'h00, 16'h0000, 16'h2100);
      neg(16'h01E1, a);
      restart();
      r = $urandom();
      neg({2'b00, r[4], 4'h0, r[3:0], 5'h01}, a);
    end
    restart();
    l100 <= 1'b1;
    wait_st(ST_LINK);
    @(negedge clk);
    chk({13'h0, link_up, speed_100, full_duplex}, 16'h0006);
    rd(5'h05, 16'h0081, 16'hFFFF);
    rd(5'h06, 16'h0000, 16'h0001);
    rd(5'h01, 16'h0020, 16'h0020);
    l100 <= 1'b0;
    wait_st(ST_BREAK);
    wait_st(ST_ABIL);
    l10 <= 1'b1;
    wait_st(ST_LINK);
    rd(5'h05, 16'h0021, 16'hFFFF);
    l10 <= 1'b0;
    wait_st(ST_ABIL);
    {l10, l100} <= 2'b11;
    repeat (8) @(negedge clk);
    rd(5'h06, 16'h0010, 16'h0010);
    {l10, l100} <= 2'b00;
    wr(5'h00, 16'h2100);
    wait_st(ST_OFF);
    rd(5'h06, 16'h0010, 16'h0010);
    repeat (3) @(negedge clk);
    chk({14'h0, speed_100, full_duplex}, 16'h0003);
    wr(5'h04, 16'h0060);
    rd(5'h04, 16'h0061, 16'hFFFF);
    wr(5'h00, 16'h1000);
    neg(16'h01E1, 16'h0061);
    wr(5'h00, 16'h3000);
    repeat (3) @(negedge clk);
    chk({14'h0, speed_100, full_duplex}, 16'h0001);
    rd(5'h02, 16'h0000, 16'hFFFF);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h01E1, 16'hFFFF);
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule : pan_ctrl_tb
